// ---- bench/twe_cmd_tb.sv ----
// self-checking bench of the three-wire eeprom command logic
// assumes twe_host drives the pins; short program time for speed
`timescale 1ns/10ps
`default_nettype none
module twe_cmd_tb;
   localparam int PROG = 200;
   localparam int LIMIT = 40000;
   logic clk = 1'h0;
   logic rst_n;
   int n_mismatch;
   int checks_done;
   int cyc;
   wire cs, lclk, sdin, wsel, dout, doe;
   // released pin shows the inverse
   wire do_pin = doe ? dout : ~dout;
   // ==================================================
   // design and host
   twe_cmd #(.PROG_CYCLES(PROG)) twe_cmd_i (
      .SYS_CLK_IN(clk), .RSTN_IN(rst_n), .CHIP_SELECT_IN(cs), .SERIAL_CLOCK_PIN_IN(lclk),
      .SERIAL_IN_PIN_IN(sdin), .WORD_WIDTH_SELECT_IN(wsel), .SERIAL_OUT_PIN_OUT(dout), .SERIAL_OUT_OE_OUT(doe));
   twe_host twe_host_i (.clk_in(clk), .do_in(do_pin), .oe_in(doe), .cs_out(cs), .lclk_out(lclk),
      .sdin_out(sdin), .wsel_out(wsel));
   always #10 clk = ~clk;
   // ==================================================
   // shared checks
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic prog(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d, input logic wr,
                       input logic busy);
      logic [1:0] first;
      logic rdy;
      twe_host_i.cmd(op, a, d, wr, 1'h0);
      twe_host_i.close_f();
      twe_host_i.status(busy ? 2 * PROG + 100 : 0, first, rdy);
      chk("status at select rise", busy ? 16'h0002 : 16'h0000, {14'h0000, first});
      chk("ready seen", {15'h0000, busy}, {15'h0000, rdy});
   endtask : prog
   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] v;
      logic [1:0] dm;
      twe_host_i.rd(a, v, dm);
      chk("dummy bit", 16'h0002, {14'h0000, dm});
      chk("read word", exp, v);
      chk("enable after select low", 16'h0000, {15'h0000, doe});
   endtask : rd_chk
   task automatic unlock(input logic [6:0] a);
      twe_host_i.cmd(2'h0, a, 16'h0000, 1'h0, 1'h1);
      twe_host_i.close_f();
   endtask : unlock
   // ==================================================
   // scenarios
   task automatic t_prog();
      logic [1:0] first;
      logic rdy;
      prog(2'h1, 7'h05, 16'hA5C3, 1'h1, 1'h0);
      unlock(7'h35);
      prog(2'h0, 7'h2A, 16'h0000, 1'h0, 1'h1);
      rd_chk(7'h00, 16'hFFFF);
      rd_chk(7'h3F, 16'hFFFF);
      prog(2'h1, 7'h05, 16'hA5C3, 1'h1, 1'h1);
      rd_chk(7'h05, 16'hA5C3);
      twe_host_i.cmd(2'h1, 7'h07, 16'h0F0F, 1'h1, 1'h0);
      twe_host_i.close_f();
      prog(2'h1, 7'h08, 16'h8001, 1'h1, 1'h1);
      rd_chk(7'h07, 16'h0F0F);
      rd_chk(7'h08, 16'h8001);
      twe_host_i.cmd(2'h1, 7'h06, 16'h3C5A, 1'h1, 1'h0);
      twe_host_i.close_f();
      repeat (PROG + 50) @(posedge clk);
      twe_host_i.status(0, first, rdy);
      chk("late select status", 16'h0000, {14'h0000, first});
      rd_chk(7'h06, 16'h3C5A);
      $display("test program sequence done");
   endtask : t_prog
   task automatic t_erase_fill();
      prog(2'h3, 7'h05, 16'h0000, 1'h0, 1'h1);
      rd_chk(7'h05, 16'hFFFF);
      rd_chk(7'h06, 16'h3C5A);
      prog(2'h0, 7'h1C, 16'h1234, 1'h1, 1'h1);
      rd_chk(7'h00, 16'h1234);
      rd_chk(7'h3F, 16'h1234);
      $display("test erase and fill done");
   endtask : t_erase_fill
   task automatic t_lock();
      twe_host_i.cmd(2'h0, 7'h0B, 16'h0000, 1'h0, 1'h0);
      twe_host_i.close_f();
      prog(2'h1, 7'h00, 16'h0000, 1'h1, 1'h0);
      prog(2'h3, 7'h01, 16'h0000, 1'h0, 1'h0);
      rd_chk(7'h00, 16'h1234);
      rd_chk(7'h01, 16'h1234);
      $display("test lock done");
   endtask : t_lock
   task automatic t_byte();
      twe_host_i.set_wsel(1'h0);
      unlock(7'h6A);
      prog(2'h1, 7'h0B, 16'h005A, 1'h1, 1'h1);
      rd_chk(7'h0B, 16'h005A);
      rd_chk(7'h0A, 16'h0034);
      twe_host_i.cmd(2'h0, 7'h15, 16'h0000, 1'h0, 1'h0);
      twe_host_i.close_f();
      prog(2'h1, 7'h0A, 16'h00FF, 1'h1, 1'h0);
      rd_chk(7'h0A, 16'h0034);
      $display("test byte mode done");
   endtask : t_byte
   // ==================================================
   // main sequence
   initial begin
      rst_n = 1'h0;
      n_mismatch = 0;
      checks_done = 0;
      cyc = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      twe_host_i.set_wsel(1'h1);
      t_prog();
      t_erase_fill();
      t_lock();
      t_byte();
      conclude();
   end
endmodule : twe_cmd_tb
`default_nettype wire

// ---- bench/twe_host.sv ----
// host model: drives select, link clock and data in, samples data out
// assumes 50 MHz clk_in; link clock 160 ns, held low outside frames
`timescale 1ns/10ps
`default_nettype none
module twe_host (
   input wire logic clk_in,
   input wire logic do_in,
   input wire logic oe_in,
   output logic cs_out,
   output logic lclk_out,
   output logic sdin_out,
   output logic wsel_out
);
   initial begin
      cs_out = 1'h0;
      lclk_out = 1'h0;
      sdin_out = 1'h0;
      wsel_out = 1'h0;
   end
   // ==================================================
   // link bit: data changes while clock low, out sampled before rise
   task automatic bit_io(input logic b, output logic [1:0] s);
      sdin_out <= b;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      s = {oe_in, do_in};
      @(posedge clk_in);
      lclk_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      lclk_out <= 1'h0;
   endtask : bit_io
   task automatic send(input logic [15:0] v, input int n);
      logic [1:0] s;
      for (int i = n - 1; i >= 0; i--) begin
         bit_io(v[i], s);
      end
   endtask : send
   task automatic set_wsel(input logic m);
      wsel_out <= m;
      @(posedge clk_in);
   endtask : set_wsel
   // ==================================================
   // frames
   // select rise, then start bit
   task automatic open_f(input logic lead0);
      cs_out <= 1'h1;
      repeat (6) @(posedge clk_in);
      if (lead0) begin
         send(16'h0000, 1);
      end
      send(16'h0001, 1);
   endtask : open_f
   task automatic close_f();
      cs_out <= 1'h0;
      repeat (6) @(posedge clk_in);
   endtask : close_f
   task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d, input logic wr,
                      input logic lead0);
      open_f(lead0);
      send({14'h0000, op}, 2);
      send({9'h000, a}, wsel_out ? 6 : 7);
      if (wr) begin
         send(d, wsel_out ? 16 : 8);
      end
   endtask : cmd
   task automatic rd(input logic [6:0] a, output logic [15:0] v, output logic [1:0] dm);
      logic [1:0] s;
      v = 16'h0000;
      cmd(2'h2, a, 16'h0000, 1'h0, 1'h0);
      bit_io(1'h0, dm);
      for (int i = (wsel_out ? 15 : 7); i >= 0; i--) begin
         bit_io(1'h0, s);
         v[i] = s[0];
      end
      close_f();
   endtask : rd
   task automatic status(input int lim, output logic [1:0] first, output logic rdy);
      cs_out <= 1'h1;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      // released pin carries no value
      first = {oe_in, oe_in & do_in};
      rdy = 1'h0;
      for (int i = 0; i < lim && !rdy; i++) begin
         @(negedge clk_in);
         rdy = oe_in === 1'h1 && do_in === 1'h1;
      end
      @(posedge clk_in);
      close_f();
   endtask : status
endmodule : twe_host
`default_nettype wire

// ---- hw/twe_cmd.sv ----
// instruction front end of a three-wire serial eeprom
// assumes pins asynchronous to SYS_CLK_IN, link clock well below a quarter of it
// Functional notes
// - frame opens on select rising, then start bit one, opcode, address
// - read is opcode 10, address 7 bits byte mode, 6 bits word mode
// - unlock is opcode 00 with top address bits 11
// - erase opcode 11 sets addressed location to all ones
// - write opcode 01 takes 8 or 16 data bits for the address
// - clear-all opcode 00 top bits 10 sets whole array to ones
// - fill-all opcode 00 top bits 01 writes data word everywhere
// - lock opcode 00 top bits 00 disables programming
// - read data shifts out, changing on serial clock rising edges
// - one zero dummy bit precedes read data
// - enable latch starts cleared after reset
// - latch stays set until lock or reset
// - read works whatever the latch state
// - erase cycle starts once opcode and address are decoded
// - write cycle starts right after the last data bit
// - select raised during cycle shows busy zero, then ready one
// - select raised after cycle end shows no status
`timescale 1ns/10ps
`default_nettype none
`include "twe_map.svh"
module twe_cmd #(
   parameter int unsigned PROG_CYCLES = `TWE_PROG_TIME_US * `TWE_CLK_MHZ,
   parameter int WORDS = `TWE_WORDS
) (
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic CHIP_SELECT_IN,
   input wire logic SERIAL_CLOCK_PIN_IN,
   input wire logic SERIAL_IN_PIN_IN,
   input wire logic WORD_WIDTH_SELECT_IN,
   output logic SERIAL_OUT_PIN_OUT,
   output logic SERIAL_OUT_OE_OUT
);
   localparam logic [23:0] PROG_LAST = 24'(PROG_CYCLES - 1);
   localparam logic [23:0] SWEEP_END = 24'(WORDS);
   localparam twe_pkg::twe_state_s RST = '{st: twe_pkg::S_IDLE, es: twe_pkg::E_IDLE, default: '0};

   twe_pkg::twe_state_s q;
   twe_pkg::twe_state_s n;
   logic [15:0] rdata;
   logic cs_on;
   logic cs_rise;
   logic lclk_rise;
   logic sdin_bit;
   logic busy;
   logic [4:0] aw_last;
   logic [4:0] dw_last;
   logic [6:0] a_full;
   logic [15:0] d_full;
   logic [1:0] sub;
   logic prog_req;
   logic lock_hit;
   logic unlock_hit;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   twe_pkg::twe_ent_s pent;
   twe_pkg::twe_ent_s rent;

   // ==================================================
   // request builder, shared by decode and read
   function automatic twe_pkg::twe_ent_s twe_mk(input logic x16, input logic all, input logic [6:0] a,
                                                 input logic [15:0] d);
      twe_pkg::twe_ent_s e;
      e.all = all;
      e.wa = x16 ? a[5:0] : a[6:1];
      e.be = (x16 || all) ? `TWE_BE_ALL : (a[0] ? `TWE_BE_HI : `TWE_BE_LO);
      e.wd = x16 ? d : {d[7:0], d[7:0]};
      return e;
   endfunction : twe_mk

   // ==================================================
   // array
   twe_mem #(
      .WORDS(WORDS)
   ) u_mem (
      .clk_in(SYS_CLK_IN),
      .wr_in(q.wr),
      .raddr_in(q.rd_a),
      .rdata_out(rdata)
   );

   // ==================================================
   // next state
   always_comb begin
      n = q;
      n.cs_s = {q.cs_s[1:0], CHIP_SELECT_IN};
      n.lclk_s = {q.lclk_s[1:0], SERIAL_CLOCK_PIN_IN};
      n.sdin_s = {q.sdin_s[0], SERIAL_IN_PIN_IN};
      n.wsel_s = {q.wsel_s[0], WORD_WIDTH_SELECT_IN};
      cs_on = q.cs_s[1];
      cs_rise = q.cs_s[1] & ~q.cs_s[2];
      lclk_rise = q.lclk_s[1] & ~q.lclk_s[2];
      sdin_bit = q.sdin_s[1];
      buf_out_valid = (q.fcnt != 2'h0);
      buf_out_ready = (q.es == twe_pkg::E_IDLE);
      busy = (q.es == twe_pkg::E_PROG) || buf_out_valid;
      aw_last = q.x16 ? `TWE_ALAST_X16 : `TWE_ALAST_X8;
      dw_last = q.x16 ? `TWE_DLAST_X16 : `TWE_DLAST_X8;
      a_full = {q.addr[5:0], sdin_bit};
      d_full = {q.data[14:0], sdin_bit};
      sub = q.x16 ? a_full[5:4] : a_full[6:5];
      rent = twe_mk(q.x16, 1'b0, a_full, 16'h0000);
      prog_req = 1'b0;
      lock_hit = 1'b0;
      unlock_hit = 1'b0;
      pent = '0;
      n.wr = '0;
      n.rd_p = {q.rd_p[0], 1'b0};
      // self-timed engine, drains the buffer
      case (q.es)
         twe_pkg::E_IDLE: begin
            if (buf_out_valid) begin
               n.cur = q.fifo[0];
               n.fifo[0] = q.fifo[1];
               n.fcnt = q.fcnt - 2'h1;
               n.es = twe_pkg::E_PROG;
               n.tmr = '0;
            end
         end
         twe_pkg::E_PROG: begin
            n.tmr = q.tmr + 24'h1;
            n.wr.we = q.cur.all ? (q.tmr < SWEEP_END) : (q.tmr == 24'h0);
            n.wr.wa = q.cur.all ? q.tmr[5:0] : q.cur.wa;
            n.wr.be = q.cur.be;
            n.wr.wd = q.cur.wd;
            if (q.tmr == PROG_LAST) begin
               n.es = twe_pkg::E_IDLE;
            end
         end
         default: begin
            n.es = twe_pkg::E_IDLE;
         end
      endcase
      // frame decode
      if (!cs_on) begin
         n.st = twe_pkg::S_IDLE;
         n.stat = 1'b0;
         n.oe_v = 1'b0;
      end else begin
         if (q.stat) begin
            n.do_v = ~busy;
         end
         case (q.st)
            twe_pkg::S_IDLE: begin
               n.st = twe_pkg::S_START;
               n.stat = busy;
               n.oe_v = busy;
               n.do_v = 1'b0;
            end
            twe_pkg::S_START: begin
               if (lclk_rise && sdin_bit == `TWE_START_BIT) begin
                  n.st = twe_pkg::S_OPC;
                  n.cnt = '0;
                  n.stat = 1'b0;
                  n.oe_v = 1'b0;
                  n.x16 = q.wsel_s[1];
               end
            end
            twe_pkg::S_OPC: begin
               if (lclk_rise) begin
                  n.opc = {q.opc[0], sdin_bit};
                  n.cnt = q.cnt + 5'h1;
                  if (q.cnt == `TWE_OPC_LAST) begin
                     n.st = twe_pkg::S_ADDR;
                     n.cnt = '0;
                  end
               end
            end
            twe_pkg::S_ADDR: begin
               if (lclk_rise) begin
                  n.addr = a_full;
                  n.cnt = q.cnt + 5'h1;
                  if (q.cnt == aw_last) begin
                     n.cnt = '0;
                     n.st = twe_pkg::S_DONE;
                     if (q.opc == `TWE_OPC_READ) begin
                        n.st = twe_pkg::S_READ;
                        n.oe_v = 1'b1;
                        n.do_v = `TWE_DUMMY_BIT;
                        n.rd_a = rent.wa;
                        n.rd_p = 2'h1;
                     end else if (q.opc == `TWE_OPC_WRITE) begin
                        n.st = twe_pkg::S_DATA;
                     end else if (q.opc == `TWE_OPC_ERASE) begin
                        prog_req = 1'b1;
                        pent = twe_mk(q.x16, 1'b0, a_full, `TWE_ERASED);
                     end else if (sub == `TWE_SUB_UNLOCK) begin
                        unlock_hit = 1'b1;
                        n.en = 1'b1;
                     end else if (sub == `TWE_SUB_LOCK) begin
                        lock_hit = 1'b1;
                        n.en = 1'b0;
                     end else if (sub == `TWE_SUB_CLEAR) begin
                        prog_req = 1'b1;
                        pent = twe_mk(q.x16, 1'b1, a_full, `TWE_ERASED);
                     end else begin
                        n.st = twe_pkg::S_DATA;
                     end
                  end
               end
            end
            twe_pkg::S_DATA: begin
               if (lclk_rise) begin
                  n.data = d_full;
                  n.cnt = q.cnt + 5'h1;
                  if (q.cnt == dw_last) begin
                     n.st = twe_pkg::S_DONE;
                     prog_req = 1'b1;
                     pent = twe_mk(q.x16, q.opc == `TWE_OPC_EXT, q.addr, d_full);
                  end
               end
            end
            twe_pkg::S_READ: begin
               if (q.rd_p[1]) begin
                  n.sh = q.x16 ? rdata : {(q.addr[0] ? rdata[15:8] : rdata[7:0]), 8'h00};
               end
               if (lclk_rise) begin
                  n.do_v = q.sh[15];
                  n.sh = {q.sh[14:0], 1'b0};
                  n.cnt = q.cnt + 5'h1;
                  if (q.cnt == dw_last) begin
                     n.st = twe_pkg::S_DONE;
                  end
               end
            end
            twe_pkg::S_DONE: begin
               n.st = twe_pkg::S_DONE;
            end
            default: begin
               n.st = twe_pkg::S_IDLE;
            end
         endcase
      end
      // two-entry buffer fill
      buf_in_ready = (n.fcnt != 2'h2);
      if (prog_req && q.en && buf_in_ready) begin
         n.fifo[n.fcnt[0]] = pent;
         n.fcnt = n.fcnt + 2'h1;
      end
   end

   // ==================================================
   // state register
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         q <= RST;
      end else begin
         q <= n;
      end
   end
   assign SERIAL_OUT_PIN_OUT = q.do_v;
   assign SERIAL_OUT_OE_OUT = q.oe_v;

   // ==================================================
   // checks
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);

   sequence s_start_seen;
      cs_on && q.st == twe_pkg::S_START && lclk_rise && sdin_bit;
   endsequence
   sequence s_read_go;
      cs_on && q.st == twe_pkg::S_ADDR && lclk_rise && q.cnt == aw_last && q.opc == `TWE_OPC_READ;
   endsequence
   sequence s_queued;
      prog_req && q.en && q.fcnt == 2'h0 && q.es == twe_pkg::E_IDLE;
   endsequence
   sequence s_engine_run;
      q.fcnt == 2'h1 ##1 q.es == twe_pkg::E_PROG && q.tmr == 24'h0 ##1 q.wr.we;
   endsequence

   property p_frame_start;
      s_start_seen |=> q.st == twe_pkg::S_OPC && q.cnt == 5'h0;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("start bit not taken");
   property p_read_fetch;
      s_read_go |=> q.st == twe_pkg::S_READ ##1 q.rd_p[1];
   endproperty
   a_read_fetch: assert property (p_read_fetch) else $error("read fetch missing");
   property p_read_dummy;
      s_read_go |=> SERIAL_OUT_OE_OUT && SERIAL_OUT_PIN_OUT == `TWE_DUMMY_BIT;
   endproperty
   a_read_dummy: assert property (p_read_dummy) else $error("dummy bit wrong");
   property p_read_shift;
      cs_on && q.st == twe_pkg::S_READ && lclk_rise |=> SERIAL_OUT_PIN_OUT == $past(q.sh[15]);
   endproperty
   a_read_shift: assert property (p_read_shift) else $error("read bit wrong");
   property p_latch_off;
      !q.en && !unlock_hit |=> !q.en;
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("latch set without unlock");
   property p_latch_hold;
      q.en && !lock_hit |=> q.en;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch lost without lock");
   property p_locked_ignore;
      prog_req && !q.en && q.fcnt == 2'h0 && q.es == twe_pkg::E_IDLE |=> q.fcnt == 2'h0 [*2];
   endproperty
   a_locked_ignore: assert property (p_locked_ignore) else $error("locked request ran");
   property p_erase_start;
      s_queued and q.st == twe_pkg::S_ADDR |=> s_engine_run;
   endproperty
   a_erase_start: assert property (p_erase_start) else $error("erase cycle late");
   property p_write_start;
      s_queued and q.st == twe_pkg::S_DATA |=> s_engine_run;
   endproperty
   a_write_start: assert property (p_write_start) else $error("write cycle late");
   property p_erase_ones;
      prog_req && q.st == twe_pkg::S_ADDR |-> pent.wd == `TWE_ERASED;
   endproperty
   a_erase_ones: assert property (p_erase_ones) else $error("erase data not ones");
   property p_sweep;
      q.es == twe_pkg::E_PROG && q.cur.all && q.tmr < SWEEP_END |=> q.wr.we && q.wr.be == `TWE_BE_ALL;
   endproperty
   a_sweep: assert property (p_sweep) else $error("array sweep gap");
   property p_status_ready;
      cs_on && q.stat && !busy && !lclk_rise |=> SERIAL_OUT_OE_OUT && SERIAL_OUT_PIN_OUT;
   endproperty
   a_status_ready: assert property (p_status_ready) else $error("ready not shown");
   property p_no_late_status;
      cs_rise && !busy |=> !SERIAL_OUT_OE_OUT;
   endproperty
   a_no_late_status: assert property (p_no_late_status) else $error("late status shown");
   property p_quiet;
      !cs_on |=> !SERIAL_OUT_OE_OUT;
   endproperty
   a_quiet: assert property (p_quiet) else $error("output driven while deselected");
endmodule : twe_cmd
`default_nettype wire

// ---- hw/twe_mem.sv ----
// word array of the eeprom, byte lanes, registered read
// assumes write and read ports driven on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "twe_map.svh"
module twe_mem #(
   parameter int WORDS = `TWE_WORDS
) (
   input wire logic clk_in,
   input wire twe_pkg::twe_wr_s wr_in,
   input wire logic [5:0] raddr_in,
   output logic [15:0] rdata_out
);
   typedef struct packed {
      logic [WORDS-1:0][15:0] arr;
      logic [15:0] rd;
   } twe_mem_s;
   twe_mem_s q;
   twe_mem_s n;
   // ==================================================
   // lane writes and read register
   always_comb begin
      n = q;
      n.rd = q.arr[raddr_in];
      for (int l = 0; l < 2; l++) begin
         if (wr_in.we && wr_in.be[l]) begin
            n.arr[wr_in.wa][l*8 +: 8] = wr_in.wd[l*8 +: 8];
         end
      end
   end
   always_ff @(posedge clk_in) begin
      q <= n;
   end
   assign rdata_out = q.rd;
endmodule : twe_mem
`default_nettype wire

// ---- pkg/twe_map.svh ----
// constants of the three-wire eeprom command logic
// assumes inclusion by bare name from design files
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH
// ==================================================
// timing
`define TWE_CLK_MHZ 50
`define TWE_PROG_TIME_US 5000
// ==================================================
// array
`define TWE_WORDS 64
`define TWE_ERASED 16'hFFFF
`define TWE_BE_ALL 2'h3
`define TWE_BE_HI 2'h2
`define TWE_BE_LO 2'h1
// ==================================================
// frame coding
`define TWE_START_BIT 1'h1
`define TWE_DUMMY_BIT 1'h0
`define TWE_OPC_EXT 2'h0
`define TWE_OPC_WRITE 2'h1
`define TWE_OPC_READ 2'h2
`define TWE_OPC_ERASE 2'h3
`define TWE_SUB_LOCK 2'h0
`define TWE_SUB_FILL 2'h1
`define TWE_SUB_CLEAR 2'h2
`define TWE_SUB_UNLOCK 2'h3
// ==================================================
// last bit index of each field
`define TWE_OPC_LAST 5'h01
`define TWE_ALAST_X8 5'h06
`define TWE_ALAST_X16 5'h05
`define TWE_DLAST_X8 5'h07
`define TWE_DLAST_X16 5'h0F
`endif

// ---- pkg/twe_pkg.sv ----
// types of the three-wire eeprom command logic
// assumes nothing of its surroundings
`default_nettype none
package twe_pkg;
   // ==================================================
   // frame and engine states
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_START = 7'h02,
      S_OPC = 7'h04,
      S_ADDR = 7'h08,
      S_DATA = 7'h10,
      S_READ = 7'h20,
      S_DONE = 7'h40
   } twe_fsm_e;
   typedef enum logic [1:0] {
      E_IDLE = 2'h1,
      E_PROG = 2'h2
   } twe_eng_e;
   // ==================================================
   // program request and array write port
   typedef struct packed {
      logic all;
      logic [5:0] wa;
      logic [1:0] be;
      logic [15:0] wd;
   } twe_ent_s;
   typedef struct packed {
      logic we;
      logic [5:0] wa;
      logic [1:0] be;
      logic [15:0] wd;
   } twe_wr_s;
   // ==================================================
   // whole state of the command logic
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] lclk_s;
      logic [1:0] sdin_s;
      logic [1:0] wsel_s;
      twe_fsm_e st;
      logic x16;
      logic [1:0] opc;
      logic [6:0] addr;
      logic [15:0] data;
      logic [4:0] cnt;
      logic en;
      logic stat;
      logic [1:0] rd_p;
      logic [5:0] rd_a;
      logic [15:0] sh;
      logic do_v;
      logic oe_v;
      twe_ent_s [1:0] fifo;
      logic [1:0] fcnt;
      twe_eng_e es;
      logic [23:0] tmr;
      twe_ent_s cur;
      twe_wr_s wr;
   } twe_state_s;
endpackage : twe_pkg
`default_nettype wire
